// ===== design/octal_dac_pkg.sv
// constants shared by the octal converter command decoder
package octal_dac_pkg;
    localparam int word_bits = 16;
    localparam int code_bits = 8;
    localparam int num_channels = 8;
    localparam int cnt_bits = 5;
    // opcode_field position and channel_index_field position
    localparam int opcode_hi = 15;
    localparam int opcode_lo = 12;
    localparam int chan_hi = 14;
    localparam int chan_lo = 12;
    // payload code position and channel mask position inside the word
    localparam int code_hi = 11;
    localparam int code_lo = 4;
    localparam int mask_hi = 7;
    localparam int mask_lo = 0;
    // frame edge counts
    localparam logic [4:0] edges_full = 5'h10;
    localparam logic [4:0] edges_least = 5'h0f;
    // opcodes
    localparam logic [3:0] op_hold = 4'h8;
    localparam logic [3:0] op_immediate = 4'h9;
    localparam logic [3:0] op_update_sel = 4'ha;
    localparam logic [3:0] op_chan_a = 4'hb;
    localparam logic [3:0] op_broadcast = 4'hc;
    localparam logic [3:0] op_pd_hiz = 4'hd;
    localparam logic [3:0] op_pd_100k = 4'he;
    localparam logic [3:0] op_pd_2k5 = 4'hf;
    // output termination codes per channel
    localparam logic [1:0] term_active = 2'h0;
    localparam logic [1:0] term_hiz = 2'h1;
    localparam logic [1:0] term_100k = 2'h2;
    localparam logic [1:0] term_2k5 = 2'h3;
    localparam logic [code_bits-1:0] code_reset = 8'h00;
endpackage

// ===== design/serial_frame_rx.sv
// serial frame receiver: samples link pins, shifts word, flags complete frames
`timescale 1ns/100ps
module serial_frame_rx (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic sclk, // link shift clock pin
    input wire logic sync_n, // frame select pin, active low
    input wire logic din, // serial data pin
    output logic word_valid, // one-cycle pulse, frame accepted
    output logic [15:0] word // completed command word
);
    logic [2:0] sclk_s_r, sclk_s_nxt;
    logic [2:0] sync_s_r, sync_s_nxt;
    logic [1:0] din_s_r, din_s_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic valid_r, valid_nxt;
    logic [15:0] word_r, word_nxt;
    logic fall, frame_end, in_frame;

    // three flops on sclk and sync_n, two on din; edges read only stages two and three
    always_comb
    begin
        sclk_s_nxt = {sclk_s_r[1:0], sclk};
        sync_s_nxt = {sync_s_r[1:0], sync_n};
        din_s_nxt = {din_s_r[0], din};
        // sclk falls while frame select is low; data sampled with it
        in_frame = ~sync_s_r[1];
        fall = sclk_s_r[2] & ~sclk_s_r[1];
        frame_end = sync_s_r[1] & ~sync_s_r[2];
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        valid_nxt = 1'b0;
        word_nxt = word_r;
        if (in_frame && fall)
        begin
            shift_nxt = {shift_r[14:0], din_s_r[1]}; // msb first
            if (cnt_r != 5'h1f)
                cnt_nxt = cnt_r + 5'h01;
        end
        if (frame_end)
        begin
            cnt_nxt = '0;
            // short frame is dropped; extra edges keep the last 16 bits
            if (cnt_r >= octal_dac_pkg::edges_full)
            begin
                valid_nxt = 1'b1;
                word_nxt = shift_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_s_r <= '0;
            sync_s_r <= 3'h7;
            din_s_r <= '0;
            shift_r <= '0;
            cnt_r <= '0;
            valid_r <= 1'b0;
            word_r <= '0;
        end
        else
        begin
            sclk_s_r <= sclk_s_nxt;
            sync_s_r <= sync_s_nxt;
            din_s_r <= din_s_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            word_r <= word_nxt;
        end
    end

    assign word_valid = valid_r;
    assign word = word_r;
endmodule

// ===== design/octal_dac_command_decoder.sv
// command decoder for an eight-channel 8-bit converter behind a 3-wire link
`timescale 1ns/100ps
module octal_dac_command_decoder #(
    parameter int channels = octal_dac_pkg::num_channels, // channel count
    parameter int code_w = octal_dac_pkg::code_bits // code width
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic sclk, // link shift clock
    input wire logic sync_n, // frame select, active low
    input wire logic din, // serial data in
    output logic [channels*code_w-1:0] chan_reg, // stored codes, A in low bits
    output logic [channels*code_w-1:0] chan_out, // output codes, A in low bits
    output logic [channels*2-1:0] chan_term, // per-channel termination
    output logic immediate_update_mode, // high in immediate mode
    output logic cmd_done // pulse when a command executes
);
    typedef enum logic [0:0] {
        hold_update_mode = 1'b0,
        imm_mode = 1'b1
    } mode_e;

    logic word_valid;
    logic [15:0] word;
    mode_e mode_r, mode_nxt;
    logic done_r, done_nxt;
    logic [3:0] opcode_field;
    logic [2:0] channel_index_field;
    logic [code_w-1:0] payload_code;
    logic [7:0] channel_mask_field;
    // per-word actions, one bit per channel and all zero between words, plus the shared pd_code
    logic [channels-1:0] reg_load; // register takes the new code
    logic [channels-1:0] out_from_code; // output takes the new code
    logic [channels-1:0] out_from_reg; // output copies its stored register
    logic [channels-1:0] pd_sel; // output is powered down
    logic [1:0] pd_code; // termination for powered-down outputs

    // link side: sampling, shifting, frame qualification
    serial_frame_rx u_rx (
        .clk(clk),
        .rstn(rstn),
        .sclk(sclk),
        .sync_n(sync_n),
        .din(din),
        .word_valid(word_valid),
        .word(word)
    );

    // power-down opcode to termination code
    function automatic logic [1:0] pd_term(input logic [3:0] op);
        case (op)
            octal_dac_pkg::op_pd_hiz: pd_term = octal_dac_pkg::term_hiz;
            octal_dac_pkg::op_pd_100k: pd_term = octal_dac_pkg::term_100k;
            default: pd_term = octal_dac_pkg::term_2k5;
        endcase
    endfunction

    // field split of the completed word
    always_comb
    begin
        opcode_field = word[octal_dac_pkg::opcode_hi:octal_dac_pkg::opcode_lo];
        channel_index_field = word[octal_dac_pkg::chan_hi:octal_dac_pkg::chan_lo];
        payload_code = word[octal_dac_pkg::code_hi:octal_dac_pkg::code_lo];
        channel_mask_field = word[octal_dac_pkg::mask_hi:octal_dac_pkg::mask_lo];
    end

    // one-hot channel select; shared by writes and the channel A command
    function automatic logic [channels-1:0] one_hot(input logic [2:0] idx);
        logic [channels-1:0] v;
        v = '0;
        for (int i = 0; i < channels; i++)
        begin
            if (idx == 3'(i))
                v[i] = 1'b1;
        end
        one_hot = v;
    endfunction

    // mask field to channel vector; channels past the mask stay unselected
    function automatic logic [channels-1:0] mask_vec(input logic [7:0] m);
        logic [channels-1:0] v;
        v = '0;
        for (int i = 0; i < channels; i++)
        begin
            if (i < $bits(m))
                v[i] = m[i];
        end
        mask_vec = v;
    endfunction

    // word decode into per-channel actions; all effects land in one cycle
    always_comb
    begin
        mode_nxt = mode_r;
        done_nxt = word_valid;
        reg_load = '0;
        out_from_code = '0;
        out_from_reg = '0;
        pd_sel = '0;
        pd_code = pd_term(opcode_field);
        if (word_valid)
        begin
            if (!opcode_field[3])
            begin
                // channel write; in hold mode the output is left alone
                reg_load = one_hot(channel_index_field);
                if (mode_r == imm_mode)
                begin
                    out_from_code = one_hot(channel_index_field);
                end
            end
            else
            begin
                case (opcode_field)
                    octal_dac_pkg::op_hold:
                    begin
                        mode_nxt = hold_update_mode;
                    end
                    octal_dac_pkg::op_immediate:
                    begin
                        mode_nxt = imm_mode;
                    end
                    octal_dac_pkg::op_update_sel:
                    begin
                        out_from_reg = mask_vec(channel_mask_field);
                    end
                    octal_dac_pkg::op_chan_a:
                    begin
                        // mode untouched, so the current mode persists
                        reg_load = one_hot('0);
                        out_from_code = one_hot('0);
                        out_from_reg = ~one_hot('0);
                    end
                    octal_dac_pkg::op_broadcast:
                    begin
                        // code taken from bits 11..4 like other writes
                        reg_load = '1;
                        out_from_code = '1;
                    end
                    default:
                    begin
                        // power down only; register contents kept
                        pd_sel = mask_vec(channel_mask_field);
                    end
                endcase
            end
        end
    end

    // mode and done pulse registers; power-on is hold mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_r <= hold_update_mode;
            done_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            done_r <= done_nxt;
        end
    end

    // one copy of channel state per channel
    genvar g;
    generate
        for (g = 0; g < channels; g++)
        begin : g_chan
            logic [code_w-1:0] reg_r, reg_nxt;
            logic [code_w-1:0] out_r, out_nxt;
            logic [1:0] term_r, term_nxt;

            // any output load wakes a powered-down channel; a load beats power down
            always_comb
            begin
                reg_nxt = reg_r;
                out_nxt = out_r;
                term_nxt = term_r;
                if (reg_load[g])
                begin
                    reg_nxt = payload_code;
                end
                if (out_from_code[g])
                begin
                    out_nxt = payload_code;
                end
                else if (out_from_reg[g])
                begin
                    out_nxt = reg_r;
                end
                if (out_from_code[g] || out_from_reg[g])
                begin
                    term_nxt = octal_dac_pkg::term_active;
                end
                else if (pd_sel[g])
                begin
                    term_nxt = pd_code;
                end
            end

            // power-on clears codes and leaves outputs active at zero
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    reg_r <= code_w'(octal_dac_pkg::code_reset);
                    out_r <= code_w'(octal_dac_pkg::code_reset);
                    term_r <= octal_dac_pkg::term_active;
                end
                else
                begin
                    reg_r <= reg_nxt;
                    out_r <= out_nxt;
                    term_r <= term_nxt;
                end
            end

            // flatten onto output buses, channel A in the low bits
            assign chan_reg[g*code_w +: code_w] = reg_r;
            assign chan_out[g*code_w +: code_w] = out_r;
            assign chan_term[g*2 +: 2] = term_r;
        end
    endgenerate

    assign immediate_update_mode = (mode_r == imm_mode);
    assign cmd_done = done_r;
endmodule

// ===== tb/octal_dac_command_decoder_props.sv
// concurrent checks on the decoder top-level ports
`timescale 1ns/100ps
module octal_dac_command_decoder_props #(
    parameter int channels = 8, // channel count
    parameter int code_w = 8 // code width
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic sclk, // link shift clock
    input wire logic sync_n, // frame select
    input wire logic din, // serial data
    input wire logic [channels*code_w-1:0] chan_reg, // stored codes
    input wire logic [channels*code_w-1:0] chan_out, // output codes
    input wire logic [channels*2-1:0] chan_term, // terminations
    input wire logic immediate_update_mode, // mode flag
    input wire logic cmd_done // execution pulse
);
    // any output that moves must land on its own register value
    function automatic logic from_regs(input logic [channels*code_w-1:0] o, p, r);
        for (int i = 0; i < channels; i++)
            if (o[i*code_w+:code_w] != p[i*code_w+:code_w] &&
                o[i*code_w+:code_w] != r[i*code_w+:code_w])
                return 1'b0;
        return 1'b1;
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // a frame still in progress, long past any earlier frame's latency
    sequence s_sel_held;
        !sync_n [*8];
    endsequence
    // channel state left alone
    sequence s_quiet;
        $stable(chan_reg) && $stable(chan_out) && $stable(chan_term);
    endsequence

    property p_reset_zero;
        $rose(rstn) |-> chan_reg == '0 && chan_out == '0 && !immediate_update_mode;
    endproperty
    property p_done_pulse;
        cmd_done |=> !cmd_done;
    endproperty
    property p_quiet;
        !cmd_done |-> s_quiet;
    endproperty
    property p_quiet_mode;
        !cmd_done |-> $stable(immediate_update_mode);
    endproperty
    property p_done_after_rise;
        cmd_done |-> $past(sync_n, 4);
    endproperty
    property p_no_done_in_frame;
        s_sel_held |-> !cmd_done;
    endproperty
    property p_loads_from_regs;
        cmd_done |-> from_regs(chan_out, $past(chan_out), chan_reg);
    endproperty
    property p_mode_alone;
        $changed(immediate_update_mode) |-> cmd_done ##0 s_quiet;
    endproperty
    property p_special_keeps_mode;
        cmd_done && !$stable(chan_out) |-> $stable(immediate_update_mode);
    endproperty

    a_reset_zero: assert property (p_reset_zero) else $error("state not clear at reset");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    a_quiet: assert property (p_quiet) else $error("channel change without done");
    a_quiet_mode: assert property (p_quiet_mode) else $error("mode change without done");
    a_done_after_rise: assert property (p_done_after_rise) else $error("done without select rise");
    a_no_done_in_frame: assert property (p_no_done_in_frame) else $error("done inside frame");
    a_loads_from_regs: assert property (p_loads_from_regs) else $error("output not from register");
    a_mode_alone: assert property (p_mode_alone) else $error("mode command touched channels");
    a_special_keeps_mode: assert property (p_special_keeps_mode) else $error("load changed mode");
endmodule

bind octal_dac_command_decoder octal_dac_command_decoder_props #(
    .channels(channels), .code_w(code_w)) i_props (
    .clk(clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .din(din),
    .chan_reg(chan_reg), .chan_out(chan_out), .chan_term(chan_term),
    .immediate_update_mode(immediate_update_mode), .cmd_done(cmd_done));

// ===== tb/host_link_model.sv
// host side of the three-wire link: frames words onto sclk, sync_n and din
`timescale 1ns/100ps
module host_link_model (
    input wire logic clk, // system clock, pacing only
    output logic sclk, // shift clock, parked high
    output logic sync_n, // frame select, active low
    output logic din // serial data, idles low
);
    // half of the 160 ns link period in system cycles
    localparam int half = 16;

    // idle link; data low between frames to save input current
    initial
    begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end

    // one frame of nf falling edges, clock parked high so select never meets a fall
    task automatic send(input logic [15:0] w, input int nf);
        @(negedge clk);
        sync_n = 1'b0;
        for (int i = 0; i < nf; i++)
        begin
            din = w[15-i];
            repeat (half) @(negedge clk);
            sclk = 1'b0;
            repeat (half) @(negedge clk);
            sclk = 1'b1;
        end
        din = 1'b0;
        repeat (half) @(negedge clk);
        sync_n = 1'b1;
        repeat (half) @(negedge clk);
    endtask
endmodule

// ===== tb/octal_dac_command_decoder_bench.sv
// self-checking bench for the octal converter command decoder
`timescale 1ns/100ps
`define CHK(n, e, s) \
    begin \
        total_checks++; \
        if ((s) !== (e)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s exp %h got %h", n, e, s); \
        end \
    end
module octal_dac_command_decoder_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    wire sclk, sync_n, din;
    logic [63:0] chan_reg, chan_out;
    logic [63:0] er = '0;
    logic [63:0] eo = '0;
    logic [15:0] chan_term;
    logic [15:0] et = '0;
    logic immediate_update_mode, cmd_done;
    logic em = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int dones = 0;

    host_link_model i_host_link (.clk(clk), .sclk(sclk), .sync_n(sync_n), .din(din));
    octal_dac_command_decoder i_octal_dac_command_decoder (
        .clk(clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .din(din),
        .chan_reg(chan_reg), .chan_out(chan_out), .chan_term(chan_term),
        .immediate_update_mode(immediate_update_mode), .cmd_done(cmd_done));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // cycle ceiling, more than three times the planned traffic; also counts done pulses
    always @(posedge clk)
    begin
        cycles++;
        if (cmd_done === 1'b1)
            dones++;
        if (cycles == 40000)
        begin
            mismatches++;
            end_sim();
        end
    end

    // expected state after one executed word
    task automatic predict(input logic [15:0] w);
        logic [7:0] c;
        c = w[11:4];
        if (!w[15])
        begin
            er[w[14:12]*8+:8] = c;
            if (em)
                {et[w[14:12]*2+:2], eo[w[14:12]*8+:8]} = {2'h0, c};
        end
        if (w[15:12] == 4'hb)
            er[7:0] = c;
        for (int i = 0; i < 8; i++)
            case (w[15:12])
                4'h8: em = 1'b0;
                4'h9: em = 1'b1;
                // bit 12 set means the channel A command: every output loads
                4'ha, 4'hb: if (w[i] || w[12]) {et[i*2+:2], eo[i*8+:8]} = {2'h0, er[i*8+:8]};
                4'hc: {et[i*2+:2], eo[i*8+:8], er[i*8+:8]} = {2'h0, c, c};
                4'hd, 4'he, 4'hf: if (w[i]) et[i*2+:2] = 2'(w[15:12] - 4'hc);
                default: ;
            endcase
    endtask

    // send a frame of nf falls; only a full frame executes
    task automatic cmd(input logic [15:0] w, input int nf);
        int n;
        n = dones + (nf == 16);
        if (nf == 16)
            predict(w);
        i_host_link.send(w, nf);
        repeat (20) if (dones != n) @(negedge clk);
        `CHK("done count", n, dones)
        `CHK("registers", er, chan_reg)
        `CHK("outputs", eo, chan_out)
        `CHK("terminations", et, chan_term)
        `CHK("mode", em, immediate_update_mode)
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        cmd(16'hc550, 15);
        for (int i = 0; i < 8; i++)
            cmd({1'b0, 3'(i), 8'(8'h11 * (i + 1)), 4'hf}, 16);
        cmd(16'ha05a, 16);
        cmd(16'h9fff, 16);
        cmd(16'h7c3a, 16);
        cmd(16'h5d20, 15);
        cmd(16'hc7e5, 16);
        cmd(16'hd081, 16);
        cmd(16'he042, 16);
        cmd(16'hf024, 16);
        cmd(16'h7990, 16);
        cmd(16'h8fff, 16);
        cmd(16'h2330, 16);
        cmd(16'hb5a0, 16);
        end_sim();
    end
endmodule
